/* hdl/lpc_bank.sv */
// AXI4-Lite register bank configuring lanes and converters 9 to 12
// Overview of operation
// - Bits 15 to 12 of the first register enable the pseudo-random pattern on lines 9 to 12, only under individual pattern select.
// - Line 9 pattern code sits in bits 11-9 and line 10 in bits 8-6 of the first register, used only under individual select.
// - Line 11 pattern code sits in bits 7-5 and line 12 in bits 4-2 of the second register, used only under individual select.
// - Bit 5 chooses truncation (0) or rounding (1) of the filter output for channels 9-16.
// - The corner value reaches the filter of converters 9-12 only while the filter enable is set.
// - Bit 0 enables the high-pass filter of converters 9-12, bypassed when 0 as by default.
// - In 16-input mode converter 9 samples pair 17 when bit 11 is 0 and pair 18 when 1.
// - In 16-input mode converter 10 samples pair 19 when bit 10 is 0 and pair 20 when 1.
// - In 16-input mode converter 11 samples pair 21 when bit 9 is 0 and pair 22 when 1.
// - In 16-input mode converter 12 samples pair 23 when bit 8 is 0 and pair 24 when 1.
`timescale 1ns/100ps
`include "lpc_defs.svh"
module lpc_bank (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [3:0]       prbs_active_ff,
    output logic [11:0]      pattern_code_ff,
    output logic [3:0]       pattern_active_ff,
    output logic             highpass_enable_group3,
    output logic [3:0]       highpass_corner_k_group3,
    output logic             highpass_round_enable_upper,
    output logic [19:0]      input_pair_ff
);
    lpc_pkg::lpc_word_t ctrl_ff;
    lpc_pkg::lpc_word_t insel_ff;
    logic               individual_pattern_select;
    logic               in16_mode_ff;
    logic [11:0]        awaddr_ff;
    logic               aw_held_ff;
    logic [31:0]        wdata_ff;
    logic [3:0]         wstrb_ff;
    logic               w_held_ff;
    logic               do_write;
    logic [15:0]        wmask;
    logic [15:0]        nxt_word;
    logic               wr_hit;
    logic [31:0]        nxt_rdata;
    logic               rd_hit;
    logic [3:0]         prbs_bits;
    logic [11:0]        pat_bits;
    logic [3:0]         pair_bits;

    assign do_write = aw_held_ff & w_held_ff & ~s_axi_bvalid;
    assign wmask    = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    // Address and data taken in either order or on the same edge, one of each held at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            awaddr_ff     <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= ~aw_held_ff & ~s_axi_awready & s_axi_awvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff    <= 1'b0;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (ce) begin
            s_axi_wready <= ~w_held_ff & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        if (awaddr_ff == `LPC_ADDR_CTRL) begin
            nxt_word = ((ctrl_ff & ~wmask) | (wdata_ff[15:0] & wmask)) & `LPC_CTRL_MASK;
        end else if (awaddr_ff == `LPC_ADDR_INSEL) begin
            // Reserved bits forced to zero regardless of what is written
            nxt_word = ((insel_ff & ~wmask) | (wdata_ff[15:0] & wmask)) & `LPC_INSEL_MASK;
        end else if (awaddr_ff == `LPC_ADDR_INDSEL || awaddr_ff == `LPC_ADDR_INMODE) begin
            nxt_word = {15'h0000, wdata_ff[0] & wstrb_ff[0]};
        end else begin
            nxt_word = `LPC_RST16;
            wr_hit   = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff                   <= `LPC_RST16;
            insel_ff                  <= `LPC_RST16;
            individual_pattern_select <= 1'b0;
            in16_mode_ff              <= 1'b0;
        end else if (ce && do_write) begin
            if (awaddr_ff == `LPC_ADDR_CTRL) begin
                ctrl_ff <= nxt_word;
            end else if (awaddr_ff == `LPC_ADDR_INSEL) begin
                insel_ff <= nxt_word;
            end else if (awaddr_ff == `LPC_ADDR_INDSEL) begin
                individual_pattern_select <= nxt_word[0];
            end else if (awaddr_ff == `LPC_ADDR_INMODE) begin
                in16_mode_ff <= nxt_word[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LPC_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit    = 1'b1;
        nxt_rdata = 32'h0000_0000;
        if (s_axi_araddr == `LPC_ADDR_CTRL) begin
            nxt_rdata = {16'h0000, ctrl_ff};
        end else if (s_axi_araddr == `LPC_ADDR_INSEL) begin
            nxt_rdata = {16'h0000, insel_ff};
        end else if (s_axi_araddr == `LPC_ADDR_INDSEL) begin
            nxt_rdata = {31'h0000_0000, individual_pattern_select};
        end else if (s_axi_araddr == `LPC_ADDR_INMODE) begin
            nxt_rdata = {31'h0000_0000, in16_mode_ff};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LPC_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= nxt_rdata;
                s_axi_rresp  <= rd_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Filter controls; corner held at zero while bypassed so no stale k leaks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            highpass_enable_group3      <= 1'b0;
            highpass_corner_k_group3    <= `LPC_K_OFF;
            highpass_round_enable_upper <= 1'b0;
        end else if (ce) begin
            highpass_enable_group3      <= ctrl_ff[`LPC_HPF_EN_BIT];
            highpass_corner_k_group3    <= ctrl_ff[`LPC_HPF_EN_BIT] ?
                                           ctrl_ff[`LPC_K_HI:`LPC_K_LO] : `LPC_K_OFF;
            // Out-of-range k passed through untouched; software keeps it in 2..10
            highpass_round_enable_upper <= ctrl_ff[`LPC_ROUND_BIT];
        end
    end

    // Bit order of the enables runs line 9 at the top
    assign prbs_bits = {ctrl_ff[`LPC_PRBS_HI], ctrl_ff[`LPC_PRBS_HI-1],
                        ctrl_ff[`LPC_PRBS_LO+1], ctrl_ff[`LPC_PRBS_LO]};
    assign pat_bits  = {insel_ff[`LPC_PAT12_HI:`LPC_PAT12_LO],
                        insel_ff[`LPC_PAT11_HI:`LPC_PAT11_LO],
                        ctrl_ff[`LPC_PAT10_HI:`LPC_PAT10_LO],
                        ctrl_ff[`LPC_PAT9_HI:`LPC_PAT9_LO]};
    assign pair_bits = insel_ff[`LPC_INSEL_HI:`LPC_INSEL_LO];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            lpc_lane_if lif ();
            assign lif.ind_sel   = individual_pattern_select;
            assign lif.prbs_en   = prbs_bits[3-g];
            assign lif.pat_code  = pat_bits[3*g +: 3];
            assign lif.in16_mode = in16_mode_ff;
            assign lif.pair_bit  = pair_bits[3-g];
            assign lif.pair_even = `LPC_PAIR_BASE + 5'(2*g);
            lpc_lane u_lane (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .lif     (lif)
            );
            assign prbs_active_ff[g]         = lif.prbs_act;
            assign pattern_active_ff[g]      = lif.pat_act;
            assign pattern_code_ff[3*g +: 3] = lif.pat_out;
            assign input_pair_ff[5*g +: 5]   = lif.pair_num;
        end
    endgenerate
endmodule : lpc_bank

/* hdl/lpc_defs.svh */
// Offsets, field positions and reset values of the lane 9-12 configuration bank
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH
`define LPC_IDX_CTRL        8'h2D
`define LPC_IDX_INSEL       8'h2F
`define LPC_ADDR_CTRL       12'h0B4
`define LPC_ADDR_INSEL      12'h0BC
`define LPC_ADDR_INDSEL     12'h100
`define LPC_ADDR_INMODE     12'h104
`define LPC_RST16           16'h0000
`define LPC_CTRL_MASK       16'hFFFF
`define LPC_INSEL_MASK      16'h0FFC
`define LPC_PRBS_HI         15
`define LPC_PRBS_LO         12
`define LPC_PAT9_HI         11
`define LPC_PAT9_LO         9
`define LPC_PAT10_HI        8
`define LPC_PAT10_LO        6
`define LPC_ROUND_BIT       5
`define LPC_K_HI            4
`define LPC_K_LO            1
`define LPC_HPF_EN_BIT      0
`define LPC_INSEL_HI        11
`define LPC_INSEL_LO        8
`define LPC_PAT11_HI        7
`define LPC_PAT11_LO        5
`define LPC_PAT12_HI        4
`define LPC_PAT12_LO        2
`define LPC_RESP_OKAY       2'h0
`define LPC_RESP_SLVERR     2'h2
`define LPC_PAIR_BASE       5'h11
`define LPC_K_OFF           4'h0
`endif

/* hdl/lpc_lane.sv */
// Registered per-line pattern and input-pair decode for one converter
`timescale 1ns/100ps
module lpc_lane (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    lpc_lane_if.lane  lif
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lif.prbs_act <= 1'b0;
            lif.pat_act  <= 1'b0;
            lif.pat_out  <= 3'h0;
        end else if (ce) begin
            lif.prbs_act <= lif.ind_sel & lif.prbs_en;
            lif.pat_act  <= lif.ind_sel;
            lif.pat_out  <= lif.ind_sel ? lif.pat_code : 3'h0;
        end
    end

    // Pair number only meaningful in 16-input mode; 0 otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lif.pair_num <= 5'h00;
        end else if (ce) begin
            lif.pair_num <= lif.in16_mode ? (lif.pair_even + {4'h0, lif.pair_bit}) : 5'h00;
        end
    end
endmodule : lpc_lane

/* hdl/lpc_lane_if.sv */
// Per-converter configuration carried from the register bank to each lane decoder
`timescale 1ns/100ps
interface lpc_lane_if;
    logic              ind_sel;
    logic              prbs_en;
    lpc_pkg::lpc_pat_t pat_code;
    logic              in16_mode;
    logic              pair_bit;
    logic [4:0]        pair_even;
    logic              prbs_act;
    logic              pat_act;
    lpc_pkg::lpc_pat_t pat_out;
    lpc_pkg::lpc_pair_t pair_num;
    modport bank (output ind_sel, prbs_en, pat_code, in16_mode, pair_bit, pair_even,
                  input prbs_act, pat_act, pat_out, pair_num);
    modport lane (input ind_sel, prbs_en, pat_code, in16_mode, pair_bit, pair_even,
                  output prbs_act, pat_act, pat_out, pair_num);
endinterface : lpc_lane_if

/* hdl/lpc_pkg.sv */
// Types shared by the lane 9-12 configuration bank
package lpc_pkg;
    typedef logic [15:0] lpc_word_t;
    typedef logic [2:0]  lpc_pat_t;
    typedef logic [4:0]  lpc_pair_t;
endpackage : lpc_pkg

/* verif/lpc_bank_checker.sv */
// Port assertions for the lane 9-12 configuration bank
`timescale 1ns/100ps
module lpc_bank_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0]  prbs_active_ff,
    input wire logic [11:0] pattern_code_ff,
    input wire logic [3:0]  pattern_active_ff,
    input wire logic        highpass_enable_group3,
    input wire logic [3:0]  highpass_corner_k_group3,
    input wire logic [19:0] input_pair_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    prbs_gated_a: assert property ((prbs_active_ff & ~pattern_active_ff) == 4'h0)
        else $error("prbs on without individual select");
    pat_low_a: assert property (pattern_active_ff[1:0] == 2'h0 |-> pattern_code_ff[5:0] == 6'h00)
        else $error("line 9/10 code without individual select");
    pat_high_a: assert property (pattern_active_ff[3:2] == 2'h0 |-> pattern_code_ff[11:6] == 6'h00)
        else $error("line 11/12 code without individual select");
    corner_gated_a: assert property (!highpass_enable_group3 |-> highpass_corner_k_group3 == 4'h0)
        else $error("corner passed while filter off");
    // Filter enable may only move one cycle after a write completes
    hpf_update_a: assert property ($changed(highpass_enable_group3) |-> $past(s_axi_bvalid))
        else $error("filter enable moved without a write");
    pair9_a: assert property (input_pair_ff[4:0] inside {5'h00, 5'h11, 5'h12})
        else $error("conv9 pair out of range");
    pair10_a: assert property (input_pair_ff[9:5] inside {5'h00, 5'h13, 5'h14})
        else $error("conv10 pair out of range");
    pair11_a: assert property (input_pair_ff[14:10] inside {5'h00, 5'h15, 5'h16})
        else $error("conv11 pair out of range");
    pair12_a: assert property ((input_pair_ff[4:0] == 5'h00) == (input_pair_ff[19:15] == 5'h00)
        ##0 input_pair_ff[19:15] inside {5'h00, 5'h17, 5'h18})
        else $error("conv12 pair wrong");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    cover property (s_axi_bvalid && !s_axi_bready);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (input_pair_ff[4:0] == 5'h12);
    cover property (highpass_corner_k_group3 == 4'hA);
endmodule : lpc_bank_checker

/* verif/tb_lanes9_12_pattern_hpf_input_cfg.sv */
// Self-checking bench for the lane 9-12 configuration bank
`timescale 1ns/100ps
`include "lpc_defs.svh"
module tb_lanes9_12_pattern_hpf_input_cfg;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, highpass_enable_group3, highpass_round_enable_upper;
    logic [11:0] s_axi_awaddr, s_axi_araddr, pattern_code_ff;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, prbs_active_ff, pattern_active_ff, highpass_corner_k_group3;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [19:0] input_pair_ff;
    int          err_total, cmp_count;
    lpc_bank dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prbs_active_ff, .pattern_code_ff,
        .pattern_active_ff, .highpass_enable_group3, .highpass_corner_k_group3,
        .highpass_round_enable_upper, .input_pair_ff);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("Compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    // Each channel is released at the edge that samples its own ready
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        // One idle edge so a following call never re-raises in the same step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic outs(input logic [3:0] pr, input logic [11:0] pc, input logic [3:0] pa,
                        input logic [5:0] hp, input logic [19:0] ip);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(prbs_active_ff, pr);
        chk(pattern_code_ff, pc);
        chk(pattern_active_ff, pa);
        chk({highpass_round_enable_upper, highpass_corner_k_group3, highpass_enable_group3}, hp);
        chk(input_pair_ff, ip);
        @(posedge aclk);
    endtask : outs
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        #50000;
        err_total++;
        close_out;
    end
    initial begin
        err_total = 0;
        cmp_count = 0;
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        outs(4'h0, 12'h000, 4'h0, 6'h00, 20'h00000);
        rd(`LPC_ADDR_CTRL, 32'h0, `LPC_RESP_OKAY);
        rd(`LPC_ADDR_INSEL, 32'h0, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INDSEL, 16'h0001, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INMODE, 16'h0001, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_CTRL, 16'hAAB5, `LPC_RESP_OKAY);
        rd(`LPC_ADDR_CTRL, 32'h0000AAB5, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INSEL, 16'h0FFC, `LPC_RESP_OKAY);
        rd(`LPC_ADDR_INSEL, 32'h00000FFC, `LPC_RESP_OKAY);
        outs(4'h5, 12'hFD5, 4'hF, 6'h35, {5'h18, 5'h16, 5'h14, 5'h12});
        // Mixed select bits catch swapped converter order; filter off hides k
        wr(`LPC_ADDR_CTRL, 16'h5054, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INSEL, 16'h05E8, `LPC_RESP_OKAY);
        outs(4'hA, 12'h5C8, 4'hF, 6'h00, {5'h18, 5'h15, 5'h14, 5'h11});
        wr(`LPC_ADDR_CTRL, 16'h0005, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INDSEL, 16'h0000, `LPC_RESP_OKAY);
        wr(`LPC_ADDR_INMODE, 16'h0000, `LPC_RESP_OKAY);
        outs(4'h0, 12'h000, 4'h0, 6'h05, 20'h00000);
        wr(12'h0F0, 16'h1234, `LPC_RESP_SLVERR);
        rd(12'h0F0, 32'h0, `LPC_RESP_SLVERR);
        rd(`LPC_ADDR_CTRL, 32'h00000005, `LPC_RESP_OKAY);
        // Clock enable low: a write must stall and the filter controls must hold
        ce <= 1'b0;
        fork
            wr(`LPC_ADDR_CTRL, 16'h0007, `LPC_RESP_OKAY);
            begin
                repeat (8) @(posedge aclk);
                chk({highpass_round_enable_upper, highpass_corner_k_group3,
                     highpass_enable_group3}, 6'h05);
                chk(s_axi_bvalid, 1'b0);
                ce <= 1'b1;
            end
        join
        outs(4'h0, 12'h000, 4'h0, 6'h07, 20'h00000);
        // Reset in mid-run clears every field again
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        outs(4'h0, 12'h000, 4'h0, 6'h00, 20'h00000);
        rd(`LPC_ADDR_CTRL, 32'h0, `LPC_RESP_OKAY);
        // Only byte lane 0 enabled: upper byte of the write must be dropped
        s_axi_wstrb <= 4'h1;
        wr(`LPC_ADDR_CTRL, 16'hFF05, `LPC_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`LPC_ADDR_CTRL, 32'h00000005, `LPC_RESP_OKAY);
        close_out;
    end
endmodule : tb_lanes9_12_pattern_hpf_input_cfg
bind lpc_bank lpc_bank_checker u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .prbs_active_ff, .pattern_code_ff,
    .pattern_active_ff, .highpass_enable_group3, .highpass_corner_k_group3, .input_pair_ff);
